// File: include/bbm_pkg.sv
/*
 Package for the two-channel bus break monitor: register offsets, field positions, reset
 values, trigger pulse widths and the structs that carry bus cycles and channel settings.
 It assumes a core-side register port with word offsets and a single clock domain.
*/
package bbm_pkg;
    localparam logic [3:0] OFS_ADDR0 = 4'h0;
    localparam logic [3:0] OFS_AMASK0 = 4'h1;
    localparam logic [3:0] OFS_DATA0 = 4'h2;
    localparam logic [3:0] OFS_DMASK0 = 4'h3;
    localparam logic [3:0] OFS_CYC0 = 4'h4;
    localparam logic [3:0] OFS_ADDR1 = 4'h5;
    localparam logic [3:0] OFS_AMASK1 = 4'h6;
    localparam logic [3:0] OFS_DATA1 = 4'h7;
    localparam logic [3:0] OFS_DMASK1 = 4'h8;
    localparam logic [3:0] OFS_CYC1 = 4'h9;
    localparam logic [3:0] OFS_CTRL = 4'hA;
    localparam int CYC_IRQ_DIS = 13;
    localparam int CYC_DATA_EN = 12;
    localparam int CYC_BUS_HI = 7;
    localparam int CYC_BUS_LO = 6;
    localparam int CYC_FD_HI = 5;
    localparam int CYC_FD_LO = 4;
    localparam int CYC_RW_HI = 3;
    localparam int CYC_RW_LO = 2;
    localparam int CYC_SZ_HI = 1;
    localparam int CYC_SZ_LO = 0;
    localparam int CTL_FLAG_HI = 15;
    localparam int CTL_FLAG_LO = 12;
    localparam int CTL_CKS_HI = 9;
    localparam int CTL_CKS_LO = 8;
    localparam int CTL_CH1_FETCH_TIMING_SELECT = 6;
    localparam int CTL_CH0_FETCH_TIMING_SELECT = 5;
    localparam logic [31:0] CTL_WMASK = 32'h0000_0360;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_CYC = 16'h0000;
    localparam logic [1:0] SEL_CPU = 2'h1;
    localparam logic [1:0] SEL_INT = 2'h2;
    localparam logic [1:0] FD_FETCH = 2'h1;
    localparam logic [1:0] FD_DATA = 2'h2;
    localparam logic [1:0] RW_READ = 2'h1;
    localparam logic [1:0] RW_WRITE = 2'h2;
    localparam logic [1:0] SZ_NONE = 2'h0;
    localparam logic [3:0] BRK_LEVEL = 4'hF;
    localparam int CLK_MHZ = 250;
    localparam int PW0_NS = 4;
    localparam int PW1_NS = 8;
    localparam int PW2_NS = 16;
    localparam int PW3_NS = 32;
    localparam logic [7:0] PW0_CYC = 8'((PW0_NS * CLK_MHZ) / 1000);
    localparam logic [7:0] PW1_CYC = 8'((PW1_NS * CLK_MHZ) / 1000);
    localparam logic [7:0] PW2_CYC = 8'((PW2_NS * CLK_MHZ) / 1000);
    localparam logic [7:0] PW3_CYC = 8'((PW3_NS * CLK_MHZ) / 1000);

    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] data;
    } bbm_cycle_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] amask;
        logic [31:0] data;
        logic [31:0] dmask;
        logic [15:0] cyc;
    } bbm_chan_s;
endpackage : bbm_pkg

// File: rtl/bbm_break_unit.sv
/*
 Break unit for one core: two channel comparators, the register file, match flags,
 break request towards the interrupt controller and the trigger pin pulse generator.
 It assumes core buses registered on clk, and a one-cycle register port from its own core.
*/
`timescale 1ns/100ps
`default_nettype none
module bbm_break_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_offset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_r,
    input wire bbm_pkg::bbm_cycle_s fetch_bus,
    input wire bbm_pkg::bbm_cycle_s mem_bus,
    input wire bbm_pkg::bbm_cycle_s int_bus,
    input wire logic fetch_retire,
    input wire logic [3:0] interrupt_mask_level,
    output logic break_req_r,
    output logic [3:0] break_level,
    output logic break_before_exec_r,
    output logic break_trigger_out_n_r
);
    bbm_pkg::bbm_chan_s ch_r [2];
    logic [31:0] ctrl_r;
    logic [7:0] pulse_cnt_r;
    logic [1:0] pend_after_r;
    wire logic [1:0] cpu_hit;
    wire logic [1:0] int_hit;

    // Per-channel comparators.
    for (genvar i = 0; i < 2; i++) begin : g_ch
        bbm_chan_match u_match (
            .clk(clk),
            .rst(rst),
            .cfg(ch_r[i]),
            .fetch_bus(fetch_bus),
            .mem_bus(mem_bus),
            .int_bus(int_bus),
            .cpu_hit_r(cpu_hit[i]),
            .int_hit_r(int_hit[i])
        );
    end

    function automatic logic [7:0] pulse_len(input logic [1:0] cks);
        case (cks)
            2'h0: pulse_len = bbm_pkg::PW0_CYC;
            2'h1: pulse_len = bbm_pkg::PW1_CYC;
            2'h2: pulse_len = bbm_pkg::PW2_CYC;
            default: pulse_len = bbm_pkg::PW3_CYC;
        endcase
    endfunction : pulse_len

    // Register decode.
    wire logic [3:0] ofs = reg_offset;
    wire logic wr_ctrl = reg_wr && (ofs == bbm_pkg::OFS_CTRL);
    wire logic [1:0] wr_sel = {reg_wr && ofs >= bbm_pkg::OFS_ADDR1 && ofs <= bbm_pkg::OFS_CYC1,
                               reg_wr && ofs <= bbm_pkg::OFS_CYC0};
    wire logic [3:0] ch_ofs = (ofs >= bbm_pkg::OFS_ADDR1) ? 4'(ofs - bbm_pkg::OFS_ADDR1) : ofs;

    // Match flags: bits 15..12 are ch1 CPU, ch0 CPU, ch1 internal, ch0 internal.
    wire logic [1:0] any_hit = cpu_hit | int_hit;
    wire logic [1:0] pcb = {ctrl_r[bbm_pkg::CTL_CH1_FETCH_TIMING_SELECT], ctrl_r[bbm_pkg::CTL_CH0_FETCH_TIMING_SELECT]};
    wire logic [1:0] irq_ok = {!ch_r[1].cyc[bbm_pkg::CYC_IRQ_DIS],
                               !ch_r[0].cyc[bbm_pkg::CYC_IRQ_DIS]};
    wire logic [3:0] flag_old = ctrl_r[bbm_pkg::CTL_FLAG_HI:bbm_pkg::CTL_FLAG_LO];
    wire logic [3:0] flag_keep = wr_ctrl ?
        (flag_old & reg_wdata[bbm_pkg::CTL_FLAG_HI:bbm_pkg::CTL_FLAG_LO]) : flag_old;
    wire logic [3:0] flag_nxt = flag_keep | {cpu_hit, int_hit};
    wire logic [31:0] ctrl_nxt = wr_ctrl ?
        ((reg_wdata & bbm_pkg::CTL_WMASK) | {16'h0000, flag_nxt, 12'h000}) :
        ((ctrl_r & bbm_pkg::CTL_WMASK) | {16'h0000, flag_nxt, 12'h000});

    // Break request: after-execution fetch breaks wait for the instruction to retire.
    wire logic [1:0] fetch_hit_now = cpu_hit & {ch_r[1].cyc[bbm_pkg::CYC_FD_LO],
                                                ch_r[0].cyc[bbm_pkg::CYC_FD_LO]};
    wire logic [1:0] defer = fetch_hit_now & pcb & irq_ok;
    wire logic [1:0] pend_nxt = fetch_retire ? 2'b00 : (pend_after_r | defer);
    wire logic [1:0] fire_now = (any_hit & irq_ok & ~defer)
                                | (fetch_retire ? (pend_after_r | defer) : 2'b00);
    wire logic [1:0] flag_by_ch = {flag_old[3] | flag_old[1], flag_old[2] | flag_old[0]};
    wire logic req_nxt = (|fire_now) || (|(flag_by_ch & irq_ok & ~pend_after_r));
    wire logic [7:0] pulse_nxt = (|any_hit) ?
        pulse_len(ctrl_r[bbm_pkg::CTL_CKS_HI:bbm_pkg::CTL_CKS_LO]) :
        ((pulse_cnt_r != 8'h00) ? 8'(pulse_cnt_r - 8'h01) : 8'h00);

    // Read mux.
    wire bbm_pkg::bbm_chan_s rd_ch = (ofs >= bbm_pkg::OFS_ADDR1) ? ch_r[1] : ch_r[0];
    wire logic [31:0] rd_word =
        (ofs == bbm_pkg::OFS_CTRL) ? ctrl_r :
        (ofs > bbm_pkg::OFS_CTRL) ? 32'h0000_0000 :
        (ch_ofs == bbm_pkg::OFS_ADDR0) ? rd_ch.addr :
        (ch_ofs == bbm_pkg::OFS_AMASK0) ? rd_ch.amask :
        (ch_ofs == bbm_pkg::OFS_DATA0) ? rd_ch.data :
        (ch_ofs == bbm_pkg::OFS_DMASK0) ? rd_ch.dmask : {16'h0000, rd_ch.cyc};

    assign break_level = bbm_pkg::BRK_LEVEL;

    // Channel registers; settings take effect the cycle after the write.
    for (genvar i = 0; i < 2; i++) begin : g_reg
        always_ff @(posedge clk) begin
            if (rst) begin
                ch_r[i] <= '{addr: bbm_pkg::RST_WORD, amask: bbm_pkg::RST_WORD,
                             data: bbm_pkg::RST_WORD, dmask: bbm_pkg::RST_WORD,
                             cyc: bbm_pkg::RST_CYC};
            end else if (wr_sel[i]) begin
                case (ch_ofs)
                    bbm_pkg::OFS_ADDR0: ch_r[i].addr <= reg_wdata;
                    bbm_pkg::OFS_AMASK0: ch_r[i].amask <= reg_wdata;
                    bbm_pkg::OFS_DATA0: ch_r[i].data <= reg_wdata;
                    bbm_pkg::OFS_DMASK0: ch_r[i].dmask <= reg_wdata;
                    default: ch_r[i].cyc <= reg_wdata[15:0];
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= bbm_pkg::RST_WORD;
            pulse_cnt_r <= 8'h00;
            pend_after_r <= 2'b00;
            break_req_r <= 1'b0;
            break_before_exec_r <= 1'b0;
            break_trigger_out_n_r <= 1'b1;
            reg_rdata_r <= bbm_pkg::RST_WORD;
        end else begin
            ctrl_r <= ctrl_nxt;
            pulse_cnt_r <= pulse_nxt;
            pend_after_r <= pend_nxt;
            break_req_r <= req_nxt;
            break_before_exec_r <= |(fire_now & ~pcb);
            break_trigger_out_n_r <= (pulse_nxt == 8'h00);
            reg_rdata_r <= reg_rd ? rd_word : reg_rdata_r;
        end
    end

    hit_sets_flag_a: assert property (@(posedge clk) disable iff (rst)
        cpu_hit[0] |=> ctrl_r[bbm_pkg::CTL_FLAG_HI - 1]) else $error("ch0 flag not set");
    one_keeps_flag_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl && flag_old[0] && reg_wdata[bbm_pkg::CTL_FLAG_LO]
        |=> ctrl_r[bbm_pkg::CTL_FLAG_LO]) else $error("write 1 cleared flag");
    zero_clears_flag_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl && !reg_wdata[bbm_pkg::CTL_FLAG_LO] && !int_hit[0]
        |=> !ctrl_r[bbm_pkg::CTL_FLAG_LO]) else $error("write 0 kept flag");
    hit_pulses_pin_a: assert property (@(posedge clk) disable iff (rst)
        (|any_hit) |=> !break_trigger_out_n_r) else $error("no trigger on hit");
    pin_idle_high_a: assert property (@(posedge clk) disable iff (rst)
        pulse_cnt_r == 8'h00 && !(|any_hit) |=> break_trigger_out_n_r)
        else $error("trigger low while idle");
    irq_dis_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (irq_ok == 2'b00) |=> !break_req_r) else $error("request with irq disabled");
    hit_requests_a: assert property (@(posedge clk) disable iff (rst)
        (|(any_hit & irq_ok & ~pcb)) |=> break_req_r) else $error("no request on hit");
    level_fixed_a: assert property (@(posedge clk) disable iff (rst)
        break_req_r |-> break_level == bbm_pkg::BRK_LEVEL) else $error("bad level");
    after_waits_a: assert property (@(posedge clk) disable iff (rst)
        pend_after_r[0] && !fetch_retire && flag_by_ch == 2'b00 && !(|any_hit)
        |=> !break_req_r) else $error("after break fired early");
endmodule : bbm_break_unit
`default_nettype wire

// File: rtl/bbm_chan_match.sv
/*
 One break channel comparator: picks the bus the cycle register names and matches it.
 It assumes that bus cycle structs arrive registered on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module bbm_chan_match (
    input wire logic clk,
    input wire logic rst,
    input wire bbm_pkg::bbm_chan_s cfg,
    input wire bbm_pkg::bbm_cycle_s fetch_bus,
    input wire bbm_pkg::bbm_cycle_s mem_bus,
    input wire bbm_pkg::bbm_cycle_s int_bus,
    output logic cpu_hit_r,
    output logic int_hit_r
);
    function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b,
                                       input logic [31:0] m);
        masked_eq = ((a ^ b) & ~m) == 32'h0000_0000;
    endfunction : masked_eq

    function automatic logic cyc_ok(input bbm_pkg::bbm_cycle_s c,
                                    input logic [15:0] s, input logic [31:0] ba,
                                    input logic [31:0] bam, input logic [31:0] bd,
                                    input logic [31:0] bdm);
        logic [1:0] fd;
        logic [1:0] rw;
        logic [1:0] sz;
        logic fd_ok;
        logic rw_ok;
        logic sz_ok;
        logic d_ok;
        fd = s[bbm_pkg::CYC_FD_HI:bbm_pkg::CYC_FD_LO];
        rw = s[bbm_pkg::CYC_RW_HI:bbm_pkg::CYC_RW_LO];
        sz = s[bbm_pkg::CYC_SZ_HI:bbm_pkg::CYC_SZ_LO];
        fd_ok = c.fetch ? fd[0] : fd[1];
        rw_ok = c.write ? rw[1] : rw[0];
        sz_ok = (sz == bbm_pkg::SZ_NONE) || (sz == c.size);
        d_ok = !s[bbm_pkg::CYC_DATA_EN] || c.fetch || masked_eq(c.data, bd, bdm);
        cyc_ok = c.valid && fd_ok && rw_ok && sz_ok && d_ok && masked_eq(c.addr, ba, bam)
                 && !(c.fetch && ba[0]);
    endfunction : cyc_ok

    wire logic [1:0] bus_sel = cfg.cyc[bbm_pkg::CYC_BUS_HI:bbm_pkg::CYC_BUS_LO];
    wire logic pairs_set = (bus_sel != 2'h0)
        && (cfg.cyc[bbm_pkg::CYC_FD_HI:bbm_pkg::CYC_FD_LO] != 2'h0)
        && (cfg.cyc[bbm_pkg::CYC_RW_HI:bbm_pkg::CYC_RW_LO] != 2'h0);
    wire bbm_pkg::bbm_cycle_s int_data_only = '{valid: int_bus.valid && !int_bus.fetch,
        fetch: 1'b0, write: int_bus.write, size: int_bus.size,
        addr: int_bus.addr, data: int_bus.data};
    wire logic cpu_fetch_hit = cyc_ok(fetch_bus, cfg.cyc, cfg.addr, cfg.amask, cfg.data,
                                      cfg.dmask);
    wire logic cpu_data_hit = cyc_ok(mem_bus, cfg.cyc, cfg.addr, cfg.amask, cfg.data,
                                     cfg.dmask);
    wire logic cpu_nxt = pairs_set && bus_sel[0] && (cpu_fetch_hit || cpu_data_hit);
    wire logic int_nxt = pairs_set && bus_sel[1] && !bus_sel[0]
        && cyc_ok(int_data_only, cfg.cyc, cfg.addr, cfg.amask, cfg.data, cfg.dmask);

    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_hit_r <= 1'b0;
            int_hit_r <= 1'b0;
        end else begin
            cpu_hit_r <= cpu_nxt;
            int_hit_r <= int_nxt;
        end
    end

    no_sel_no_hit_a: assert property (@(posedge clk) disable iff (rst)
        !pairs_set |=> !cpu_hit_r && !int_hit_r) else $error("hit with select pair 00");
endmodule : bbm_chan_match
`default_nettype wire

// File: tb/bbm_core_model.sv
/*
 Interrupt controller stand-in for the break unit bench: priority decision against the core mask.
 It assumes one clock domain; the decision is combinational on the request level.
*/
`timescale 1ns/100ps
`default_nettype none
module bbm_core_model (
    input wire logic break_req,
    input wire logic [3:0] break_level,
    input wire logic [3:0] mask_level,
    output logic accept
);
    // The request is taken only while its level is above the core mask.
    assign accept = break_req && (break_level > mask_level);
endmodule : bbm_core_model
`default_nettype wire

// File: tb/tb_bbm_break_unit.sv
/*
 Self-checking bench for one break unit: register port, bus cycles, trigger pulses and flags.
 It assumes the core model in its own file and a 250 MHz clock with synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_bbm_break_unit;
    localparam logic [31:0] BA = 32'h0000_1000;
    localparam logic [31:0] BD = 32'h5A5A_5A5A;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_offset = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata_r;
    bbm_pkg::bbm_cycle_s fb = '0;
    bbm_pkg::bbm_cycle_s mb = '0;
    bbm_pkg::bbm_cycle_s ib = '0;
    logic fetch_retire = 1'b0;
    logic [3:0] lvl = 4'h0;
    logic break_req_r, before_exec, trig_n, accept, req_cap, acc_cap;
    logic [3:0] break_level;
    logic [9:0] trig_q [$];
    logic [31:0] rd_q [$];
    logic rd_taken = 1'b0;
    logic [1:0] cks = 2'h0;
    int fail_count = 0;
    int tests_run = 0;
    int low_cnt = 0;

    always #2 clk = ~clk;

    bbm_break_unit uut (.clk(clk), .rst(rst), .reg_offset(reg_offset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .fetch_bus(fb),
        .mem_bus(mb), .int_bus(ib), .fetch_retire(fetch_retire), .interrupt_mask_level(lvl),
        .break_req_r(break_req_r), .break_level(break_level),
        .break_before_exec_r(before_exec), .break_trigger_out_n_r(trig_n));
    bbm_core_model core (.break_req(break_req_r), .break_level(break_level), .mask_level(lvl),
        .accept(accept));

    task automatic stop_test;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch read at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_rd

    task automatic check_trig(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch pulse at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_trig

    always @(posedge clk) rd_taken <= reg_rd;

    // Takes the oldest note whenever read data or a finished trigger pulse shows up.
    always @(negedge clk) begin
        if (rd_taken && rd_q.size() != 0) begin
            check_rd(reg_rdata_r, rd_q.pop_front());
        end
        if (trig_n !== 1'b1) begin
            if (low_cnt == 0) begin
                req_cap = break_req_r;
                acc_cap = accept;
            end
            low_cnt++;
        end else if (low_cnt != 0) begin
            check_trig({req_cap, acc_cap, 8'(low_cnt)},
                       trig_q.size() != 0 ? trig_q.pop_front() : 10'h3FF);
            low_cnt = 0;
        end
    end

    task automatic wr(input logic [3:0] o, input logic [31:0] d);
        @(negedge clk);
        reg_offset = o;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] o, input logic [31:0] e);
        rd_q.push_back(e);
        @(negedge clk);
        reg_offset = o;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
    endtask : rd

    function automatic logic [15:0] mk(input logic irq, den, input logic [1:0] bs, fd, rw, sz);
        return {2'b00, irq, den, 4'h0, bs, fd, rw, sz};
    endfunction : mk

    function automatic bbm_pkg::bbm_cycle_s bc(input logic f, w, input logic [1:0] sz,
        input logic [31:0] a, d);
        return {1'b1, f, w, sz, a, d};
    endfunction : bc

    function automatic logic [9:0] hn();
        return {1'b1, lvl != 4'hF, 8'(1 << cks)};
    endfunction : hn

    // Other registers first, cycle register last; data mask zero, address mask low nibble.
    task automatic setch(input int ch, input logic [31:0] a, input logic [15:0] cyc);
        logic [3:0] b;
        b = 4'(ch * 5);
        wr(b, a);
        wr(b + 4'h1, 32'h0000_000F);
        wr(b + 4'h2, BD);
        wr(b + 4'h3, 32'h0000_0000);
        wr(b + 4'h4, {16'h0000, cyc});
    endtask : setch

    task automatic fire(input int sel, input bbm_pkg::bbm_cycle_s c, input logic [9:0] note,
        input logic [3:0] fl);
        if (note != 10'h000) trig_q.push_back(note);
        @(negedge clk);
        case (sel)
            0: fb = c;
            1: mb = c;
            default: ib = c;
        endcase
        @(negedge clk);
        fb.valid = 1'b0;
        mb.valid = 1'b0;
        ib.valid = 1'b0;
        repeat (12) @(negedge clk);
        wr(bbm_pkg::OFS_CTRL, {16'h0000, 4'hF, 2'b00, cks, 8'h00});
        rd(bbm_pkg::OFS_CTRL, {16'h0000, fl, 2'b00, cks, 8'h00});
        wr(bbm_pkg::OFS_CTRL, {22'h00_0000, cks, 8'h00});
    endtask : fire

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        void'($urandom(34297));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 12; i++) rd(4'(i), 32'h0000_0000);
        wr(4'hB, 32'hFFFF_FFFF);
        rd(4'hB, 32'h0000_0000);
        wr(bbm_pkg::OFS_CTRL, 32'hFFFF_FFFF);
        rd(bbm_pkg::OFS_CTRL, bbm_pkg::CTL_WMASK);
        wr(bbm_pkg::OFS_CTRL, 32'h0000_0000);
        r = $urandom;
        wr(bbm_pkg::OFS_AMASK1, r);
        rd(bbm_pkg::OFS_AMASK1, r);
        setch(0, BA, mk(0, 0, 2'h1, 2'h2, 2'h3, 2'h0));
        for (int k = 0; k < 4; k++) begin
            cks = 2'(k);
            wr(bbm_pkg::OFS_CTRL, {22'h00_0000, cks, 8'h00});
            lvl = 4'($urandom_range(14));
            fire(1, bc(0, 1, 2'h3, BA | 32'($urandom_range(15)), $urandom), hn(), 4'h4);
        end
        fire(1, bc(0, 0, 2'h1, BA | 32'h0000_0010, BD), 10'h000, 4'h0);
        for (int j = 0; j < 3; j++) begin
            setch(0, BA, mk(0, 0, 2'h1, 2'h2, 2'h3, 2'h0) & ~(16'h000C << (2 * j)));
            fire(1, bc(0, 0, 2'h3, BA, BD), 10'h000, 4'h0);
        end
        setch(0, BA, mk(0, 0, 2'h1, 2'h2, 2'h1, 2'h0));
        fire(1, bc(0, 1, 2'h3, BA, BD), 10'h000, 4'h0);
        setch(0, BA, mk(0, 1, 2'h1, 2'h2, 2'h3, 2'h3));
        fire(1, bc(0, 0, 2'h1, BA, BD), 10'h000, 4'h0);
        fire(1, bc(0, 0, 2'h3, BA, ~BD), 10'h000, 4'h0);
        fire(1, bc(0, 0, 2'h3, BA, BD), hn(), 4'h4);
        setch(0, BA, mk(0, 0, 2'h2, 2'h3, 2'h3, 2'h0));
        fire(2, bc(1, 0, 2'h3, BA, BD), 10'h000, 4'h0);
        fire(2, bc(0, 0, 2'h3, BA, BD), hn(), 4'h1);
        setch(0, BA | 32'h0000_0001, mk(0, 0, 2'h1, 2'h1, 2'h1, 2'h0));
        fire(0, bc(1, 0, 2'h2, BA, BD), 10'h000, 4'h0);
        setch(0, BA, mk(0, 0, 2'h1, 2'h1, 2'h1, 2'h0));
        fire(0, bc(1, 0, 2'h2, BA, BD), hn(), 4'h4);
        // After-execution fetch break: pulse now, request held back until retire.
        wr(bbm_pkg::OFS_CTRL, {22'h00_0000, cks, 8'h20});
        fire(0, bc(1, 0, 2'h2, BA, BD), {2'b00, 8'(1 << cks)}, 4'h4);
        wr(bbm_pkg::OFS_CTRL, {22'h00_0000, cks, 8'h20});
        @(negedge clk);
        fetch_retire = 1'b1;
        @(negedge clk);
        fetch_retire = 1'b0;
        check_rd({30'h0, break_req_r, before_exec}, 32'h0000_0002);
        wr(bbm_pkg::OFS_CTRL, {22'h00_0000, cks, 8'h00});
        setch(0, BA, mk(1, 0, 2'h1, 2'h2, 2'h3, 2'h0));
        fire(1, bc(0, 0, 2'h3, BA, BD), {2'b00, 8'(1 << cks)}, 4'h4);
        setch(0, BA, mk(0, 0, 2'h1, 2'h2, 2'h3, 2'h0));
        lvl = 4'hF;
        fire(1, bc(0, 0, 2'h3, BA, BD), hn(), 4'h4);
        lvl = 4'h3;
        setch(1, BA, mk(0, 0, 2'h1, 2'h2, 2'h3, 2'h0));
        fire(1, bc(0, 0, 2'h3, BA, BD), hn(), 4'hC);
        wr(bbm_pkg::OFS_CYC0, 32'h0000_0000);
        fire(1, bc(0, 0, 2'h3, BA, BD), hn(), 4'h8);
        repeat (4) @(negedge clk);
        check_rd(32'(trig_q.size()), 32'h0000_0000);
        stop_test();
    end
endmodule : tb_bbm_break_unit
`default_nettype wire
